// ==== uscf_defs.svh ====
// register offsets, field positions, reset values and timing constants of the serial port
`ifndef USCF_DEFS_SVH
`define USCF_DEFS_SVH
// register byte offsets on the bus
`define USCF_OFS_CTRL 8'h00
`define USCF_OFS_DATA 8'h04
`define USCF_OFS_DIV 8'h08
`define USCF_OFS_AUX 8'h0C
// control register field positions
`define USCF_BIT_MODE 7
`define USCF_BIT_FIXED 6
`define USCF_BIT_AMEN 5
`define USCF_BIT_REN 4
`define USCF_BIT_TB9 3
`define USCF_BIT_RB9 2
`define USCF_BIT_TI 1
`define USCF_BIT_RI 0
// auxiliary register field positions
`define USCF_BIT_IEN 0
`define USCF_BIT_TXBUSY 1
`define USCF_BIT_FULL 2
`define USCF_BIT_RXBUSY 3
// reset values
`define USCF_CTRL_RESET 8'h40
`define USCF_DATA_RESET 8'h00
// timing: system clock and default line rate
`define USCF_CLK_HZ 250000000
`define USCF_BAUD_DEFAULT 115200
`endif

// ==== uscf_pkg.sv ====
// types shared by the serial port modules
package uscf_pkg;
	// transmit sequencer states, one-hot
	typedef enum logic [4:0] {
		TX_IDLE = 5'b00001,
		TX_START = 5'b00010,
		TX_DATA = 5'b00100,
		TX_NINTH = 5'b01000,
		TX_STOP = 5'b10000
	} uscf_tx_state_t;
	// receive sequencer states, one-hot
	typedef enum logic [4:0] {
		RX_IDLE = 5'b00001,
		RX_START = 5'b00010,
		RX_DATA = 5'b00100,
		RX_NINTH = 5'b01000,
		RX_STOP = 5'b10000
	} uscf_rx_state_t;
endpackage : uscf_pkg

// ==== uscf_stream_if.sv ====
// valid/ready word stream between the port's own modules
`timescale 1ns/10ps
interface uscf_stream_if #(parameter int WIDTH = 8);
	logic valid; // word offered
	logic ready; // word accepted when both high
	logic [WIDTH-1:0] data; // the word
	// side that offers words
	modport prod (output valid, output data, input ready);
	// side that takes words
	modport cons (input valid, input data, output ready);
endinterface : uscf_stream_if

// ==== uscf_fifo.sv ====
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module uscf_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic sysClk,
	input wire logic nrst,
	uscf_stream_if.cons inSide,
	uscf_stream_if.prod outSide
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] store [DEPTH]; // entries, indexed by pointer
	logic [AW-1:0] wrPtr; // next slot to fill
	logic [AW-1:0] rdPtr; // oldest slot
	logic [AW:0] level; // words held
	logic push; // write this cycle
	logic pop; // read this cycle

	assign push = inSide.valid && inSide.ready;
	assign pop = outSide.valid && outSide.ready;
	// honest full and empty straight from the level
	assign inSide.ready = (level != DEPTH[AW:0]);
	assign outSide.valid = (level != '0);
	assign outSide.data = store[rdPtr];

	// pointers and level; wrap handled explicitly so depth need not be a power of two
	always_ff @(posedge sysClk or negedge nrst) begin
		if (!nrst) begin
			wrPtr <= '0;
			rdPtr <= '0;
			level <= '0;
		end else begin
			if (push) begin
				wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
			end
			level <= level + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// storage, one flop group per entry
	for (genvar i = 0; i < DEPTH; i++) begin : gEntry
		always_ff @(posedge sysClk or negedge nrst) begin
			if (!nrst) begin
				store[i] <= '0;
			end else if (push && wrPtr == AW'(i)) begin
				store[i] <= inSide.data;
			end
		end
	end
endmodule : uscf_fifo

// ==== uscf_rx.sv ====
// receive sequencer: start detect, mid-bit sampling, frame end pulse
`timescale 1ns/10ps
module uscf_rx import uscf_pkg::*; (
	input wire logic sysClk,
	input wire logic nrst,
	input wire logic rxLine,
	input wire logic enable,
	input wire logic nineBit,
	input wire logic [15:0] bitTicks,
	output logic frameDone,
	output logic [7:0] rxData,
	output logic rxNinth,
	output logic stopLevel,
	output logic busy
);
	uscf_rx_state_t state; // sequencer state
	logic [15:0] cnt; // cycles left in current bit
	logic [2:0] idx; // data bit index

	assign busy = (state != RX_IDLE);

	// sequencer; a cleared enable drops any frame in progress
	always_ff @(posedge sysClk or negedge nrst) begin
		if (!nrst) begin
			state <= RX_IDLE;
			cnt <= '0;
			idx <= '0;
			rxData <= '0;
			rxNinth <= 1'b0;
			stopLevel <= 1'b0;
			frameDone <= 1'b0;
		end else begin
			frameDone <= 1'b0;
			if (cnt != '0) begin
				cnt <= cnt - 1'b1;
			end
			case (state)
				RX_IDLE: begin
					if (enable && !rxLine) begin
						state <= RX_START;
						cnt <= bitTicks >> 1;
					end
				end
				RX_START: begin
					// recheck at mid start bit to reject glitches
					if (cnt == '0) begin
						state <= rxLine ? RX_IDLE : RX_DATA;
						cnt <= bitTicks - 1'b1;
						idx <= '0;
					end
				end
				RX_DATA: begin
					if (cnt == '0) begin
						rxData <= {rxLine, rxData[7:1]};
						idx <= idx + 1'b1;
						cnt <= bitTicks - 1'b1;
						if (idx == 3'd7) begin
							state <= nineBit ? RX_NINTH : RX_STOP;
						end
					end
				end
				RX_NINTH: begin
					if (cnt == '0) begin
						rxNinth <= rxLine;
						cnt <= bitTicks - 1'b1;
						state <= RX_STOP;
					end
				end
				RX_STOP: begin
					// frame ends at the stop sample, not at the end of the stop bit
					if (cnt == '0) begin
						stopLevel <= rxLine;
						frameDone <= 1'b1;
						state <= RX_IDLE;
					end
				end
				default: state <= RX_IDLE;
			endcase
			if (!enable) begin
				state <= RX_IDLE;
			end
		end
	end
endmodule : uscf_rx

// ==== uscf_serial_port.sv ====
// serial port with control flags, apb registers, transmit fifo and transmit sequencer
//
// Function
// - receive only while receive enable is 1
// - nine-bit mode sends ninth transmit bit
// - eight-bit mode ignores ninth transmit bit
// - eight-bit mode: stop level into ninth receive
// - nine-bit mode: ninth data into ninth receive
// - eight-bit: transmit flag after byte shifted
// - nine-bit: transmit flag at stop start
// - transmit flag raises enabled interrupt request
// - only software clears transmit flag
// - receive flag set at stop sample
// - receive flag raises enabled interrupt request
// - only software clears receive flag
// - mode bit: 0 eight-bit, 1 nine-bit
// - address match nine-bit: only ninth-bit-one frames
// - address match eight-bit: only valid stop
`timescale 1ns/10ps
`include "uscf_defs.svh"
module uscf_serial_port import uscf_pkg::*; #(
	parameter int BAUD = `USCF_BAUD_DEFAULT,
	parameter int FIFO_DEPTH = 8
) (
	input wire logic sysClk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxdPin,
	output logic txdPin,
	output logic irqRequest
);
	////////////////////////////////////////////////////////////////////////////////
	// constants
	// cycles per bit at the system clock, rounded down
	// rounding down makes the line at most one clock per bit too fast
	localparam int BIT_CYCLES = `USCF_CLK_HZ / BAUD;
	localparam logic [15:0] DIV_RESET = 16'(BIT_CYCLES);

	////////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [7:0] ctrl; // control register image, bit 6 fixed
	logic [7:0] rxLatch; // last accepted received byte
	logic [15:0] bitTicks; // bit length in cycles
	logic irqEnable; // port interrupt enable
	logic rxMeta; // first synchroniser stage
	logic rxSync; // second stage, safe to read
	logic accessPh; // access phase seen
	logic doWrite; // write takes effect this edge
	logic hitCtrl; // address decodes
	logic hitData;
	logic hitDiv;
	logic hitAux;
	logic mapped; // any of the four registers
	// flag events: one-cycle pulses that the flag logic turns into sticky bits
	logic tiSet; // transmit complete event
	logic riSet; // receive complete event
	// receiver results, held until the next frame overwrites them
	logic rxDone; // frame finished pulse from receiver
	logic [7:0] rxByte; // assembled data byte
	logic rxNinth; // ninth data bit of a nine-bit frame
	logic rxStop; // sampled stop level
	logic rxBusy; // frame in progress
	logic frameOk; // frame passes address match filter
	logic nineMode; // frame mode select
	// transmit sequencer; counts down one bit length per bit
	uscf_tx_state_t txState; // transmit sequencer
	logic [15:0] txCnt; // cycles left in bit
	logic [2:0] txIdx; // data bit index
	logic [7:0] txShift; // outgoing byte
	logic txNinth; // ninth bit latched for this frame
	logic [31:0] next_prdata; // read mux

	// fifo carriers: bus side to fifo, fifo to sequencer
	// the fifo lets software queue a burst without polling the busy bit
	uscf_stream_if #(.WIDTH(8)) wrIf ();
	uscf_stream_if #(.WIDTH(8)) rdIf ();

	////////////////////////////////////////////////////////////////////////////////
	// address decode
	// full byte address compare; any other address answers with an error
	assign hitCtrl = (paddr == `USCF_OFS_CTRL);
	assign hitData = (paddr == `USCF_OFS_DATA);
	assign hitDiv = (paddr == `USCF_OFS_DIV);
	assign hitAux = (paddr == `USCF_OFS_AUX);
	assign mapped = hitCtrl || hitData || hitDiv || hitAux;
	assign nineMode = ctrl[`USCF_BIT_MODE];
	// the write lands on the edge where pready is seen high
	assign accessPh = psel && penable;
	assign doWrite = accessPh && pready && pwrite && mapped;

	// data writes go into the fifo; pready was only raised once it had room
	assign wrIf.valid = doWrite && hitData;
	assign wrIf.data = pwdata[7:0];
	// sequencer takes a word only when idle
	assign rdIf.ready = (txState == TX_IDLE);

	////////////////////////////////////////////////////////////////////////////////
	// transmit fifo
	uscf_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) txFifo (
		.sysClk(sysClk),
		.nrst(nrst),
		.inSide(wrIf.cons),
		.outSide(rdIf.prod)
	);

	////////////////////////////////////////////////////////////////////////////////
	// receive line synchroniser; only the second stage is read
	// both stages reset to the idle level so no false start follows reset
	always_ff @(posedge sysClk or negedge nrst) begin
		if (!nrst) begin
			rxMeta <= 1'b1;
			rxSync <= 1'b1;
		end else begin
			rxMeta <= rxdPin;
			rxSync <= rxMeta;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// receiver
	// the receiver drops back to idle whenever receive enable is low
	// receive enable gates receiver
	uscf_rx receiver (
		.sysClk(sysClk),
		.nrst(nrst),
		.rxLine(rxSync),
		.enable(ctrl[`USCF_BIT_REN]),
		.nineBit(nineMode),
		.bitTicks(bitTicks),
		.frameDone(rxDone),
		.rxData(rxByte),
		.rxNinth(rxNinth),
		.stopLevel(rxStop),
		.busy(rxBusy)
	);

	// address match filter on a finished frame
	// judged on the pulse that ends the frame, when ninth and stop levels are fresh
	always_comb begin
		frameOk = 1'b1;
		if (ctrl[`USCF_BIT_AMEN]) begin
			frameOk = nineMode ? rxNinth : rxStop;
		end
	end
	assign riSet = rxDone && frameOk;

	////////////////////////////////////////////////////////////////////////////////
	// apb answer: one wait state, more while a data write meets a full fifo, then pready for one cycle
	// registering pready costs one cycle per access but keeps every bus output
	// straight from a flop; prdata is captured here so it stands with pready
	always_ff @(posedge sysClk or negedge nrst) begin
		if (!nrst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			// a data write waits while the fifo is full, stalling the master
			if (accessPh && !pready && !(pwrite && hitData && !wrIf.ready)) begin
				pready <= 1'b1;
				pslverr <= !mapped;
				prdata <= pwrite ? '0 : next_prdata;
			end
		end
	end

	// read mux; unused bits read as zero
	// decoded from the address alone; reading the data register has no side effect
	always_comb begin
		next_prdata = '0;
		if (hitCtrl) begin
			next_prdata[7:0] = ctrl;
		end else if (hitData) begin
			next_prdata[7:0] = rxLatch;
		end else if (hitDiv) begin
			next_prdata[15:0] = bitTicks;
		end else if (hitAux) begin
			next_prdata[`USCF_BIT_IEN] = irqEnable;
			next_prdata[`USCF_BIT_TXBUSY] = (txState != TX_IDLE);
			next_prdata[`USCF_BIT_FULL] = !wrIf.ready;
			next_prdata[`USCF_BIT_RXBUSY] = rxBusy;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control register and flags
	// a software write and a hardware set may meet on one edge; the set is
	// written last so it wins, and a flag event is never lost to a late clear
	always_ff @(posedge sysClk or negedge nrst) begin
		if (!nrst) begin
			ctrl <= `USCF_CTRL_RESET;
		end else begin
			if (doWrite && hitCtrl) begin
				ctrl[`USCF_BIT_MODE] <= pwdata[`USCF_BIT_MODE];
				ctrl[`USCF_BIT_AMEN:`USCF_BIT_RI] <= pwdata[`USCF_BIT_AMEN:`USCF_BIT_RI];
			end
			if (tiSet) begin
				ctrl[`USCF_BIT_TI] <= 1'b1;
			end
			if (riSet) begin
				ctrl[`USCF_BIT_RI] <= 1'b1;
				ctrl[`USCF_BIT_RB9] <= nineMode ? rxNinth : rxStop;
			end
			// bit 6 always reads one
			ctrl[`USCF_BIT_FIXED] <= 1'b1;
		end
	end

	// receive latch, divider and interrupt enable
	// the latch only moves on an accepted frame, so filtered frames leave it alone
	always_ff @(posedge sysClk or negedge nrst) begin
		if (!nrst) begin
			rxLatch <= `USCF_DATA_RESET;
			bitTicks <= DIV_RESET;
			irqEnable <= 1'b0;
		end else begin
			if (riSet) begin
				rxLatch <= rxByte;
			end
			// a zero divider would stall the sequencers, so it is clamped to one
			if (doWrite && hitDiv) begin
				bitTicks <= (pwdata[15:0] == '0) ? 16'h0001 : pwdata[15:0];
			end
			if (doWrite && hitAux) begin
				irqEnable <= pwdata[`USCF_BIT_IEN];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// interrupt request
	// registered, so the request trails its flag by one cycle
	// a write that disables the request drops it on the following edge
	always_ff @(posedge sysClk or negedge nrst) begin
		if (!nrst) begin
			irqRequest <= 1'b0;
		end else begin
			irqRequest <= irqEnable && (ctrl[`USCF_BIT_TI] || ctrl[`USCF_BIT_RI]);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// transmit sequencer; receive enable plays no part here
	// a frame is start, eight data bits lsb first, an optional ninth bit and stop
	// the next fifo word is taken only back in idle, so frames never overlap
	// transmit independent of receive
	always_ff @(posedge sysClk or negedge nrst) begin
		if (!nrst) begin
			txState <= TX_IDLE;
			txCnt <= '0;
			txIdx <= '0;
			txShift <= '0;
			txNinth <= 1'b1;
			txdPin <= 1'b1;
			tiSet <= 1'b0;
		end else begin
			tiSet <= 1'b0;
			if (txCnt != '0) begin
				txCnt <= txCnt - 1'b1;
			end
			case (txState)
				TX_IDLE: begin
					// line rests high; a waiting fifo word starts a frame at once
					txdPin <= 1'b1;
					if (rdIf.valid) begin
						txShift <= rdIf.data;
						// ninth bit taken at frame start
						txNinth <= nineMode ? ctrl[`USCF_BIT_TB9] : 1'b1;
						txdPin <= 1'b0;
						txCnt <= bitTicks - 1'b1;
						txState <= TX_START;
					end
				end
				TX_START: begin
					// start bit done; first data bit goes out
					if (txCnt == '0) begin
						txdPin <= txShift[0];
						txShift <= {1'b0, txShift[7:1]};
						txIdx <= '0;
						txCnt <= bitTicks - 1'b1;
						txState <= TX_DATA;
					end
				end
				TX_DATA: begin
					// shift the next bit, or leave the data phase after bit seven
					if (txCnt == '0) begin
						txCnt <= bitTicks - 1'b1;
						txIdx <= txIdx + 1'b1;
						if (txIdx != 3'd7) begin
							txdPin <= txShift[0];
							txShift <= {1'b0, txShift[7:1]};
						end else if (nineMode) begin
							txdPin <= txNinth;
							txState <= TX_NINTH;
						end else begin
							tiSet <= 1'b1;
							txdPin <= 1'b1;
							txState <= TX_STOP;
						end
					end
				end
				TX_NINTH: begin
					// ninth bit done; the stop bit follows
					if (txCnt == '0) begin
						tiSet <= 1'b1;
						txdPin <= 1'b1;
						txCnt <= bitTicks - 1'b1;
						txState <= TX_STOP;
					end
				end
				TX_STOP: begin
					// stop bit already on the line; wait out its full length
					if (txCnt == '0) begin
						txState <= TX_IDLE;
					end
				end
				default: txState <= TX_IDLE;
			endcase
		end
	end
endmodule : uscf_serial_port

// ==== uscf_serial_port_monitor.sv ====
// concurrent checks on the serial port pins and bus
`timescale 1ns/10ps
`include "uscf_defs.svh"
module uscf_serial_port_monitor (
	input wire logic sysClk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rxdPin,
	input wire logic txdPin,
	input wire logic irqRequest
);
	logic wrDone; // completed write, the only edge that changes a shadow
	logic ienQ; // shadow of the interrupt enable
	logic txSeen; // a byte has been handed over for sending
	assign wrDone = psel && penable && pready && pwrite;
	// shadows follow completed writes only
	always_ff @(posedge sysClk or negedge nrst) begin
		if (!nrst) begin
			ienQ <= 1'b0;
			txSeen <= 1'b0;
		end else if (wrDone) begin
			ienQ <= (paddr == `USCF_OFS_AUX) ? pwdata[0] : ienQ;
			txSeen <= txSeen || (paddr == `USCF_OFS_DATA);
		end
	end
	default clocking cb @(posedge sysClk);
	endclocking
	default disable iff (!nrst);
	// start bit lasts the divider of 8 that the bench programs
	sequence startBit;
		(!txdPin) [*8];
	endsequence
	sequence flagWrite;
		wrDone && (paddr == `USCF_OFS_CTRL || paddr == `USCF_OFS_AUX);
	endsequence
	AST_PREADY_PHASE: assert property (pready |-> psel && penable) else $error("ready outside access");
	AST_ONE_WAIT: assert property (psel && penable && !pready && paddr != `USCF_OFS_DATA |=> pready)
		else $error("register access not one wait state");
	AST_SLVERR_MAP: assert property (pready |-> pslverr != (paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}))
		else $error("error response does not match address map");
	AST_CTRL_BIT6: assert property (pready && !pwrite && paddr == `USCF_OFS_CTRL |-> prdata[6] && prdata[31:8] == 24'h00_0000)
		else $error("control read upper bits wrong");
	AST_START_LEN: assert property ($fell(txdPin) |-> startBit) else $error("start bit length wrong");
	AST_TXD_IDLE: assert property (!txSeen |-> txdPin) else $error("transmit line left idle without data");
	AST_IRQ_OFF: assert property (!ienQ && !$past(ienQ) |-> !irqRequest) else $error("request while disabled");
	AST_IRQ_RISE: assert property ($rose(irqRequest) |-> ienQ || $past(ienQ)) else $error("request rose disabled");
	AST_IRQ_HOLD: assert property ($fell(irqRequest) |-> $past(wrDone, 2) && ($past(paddr, 2) == `USCF_OFS_CTRL || $past(paddr, 2) == `USCF_OFS_AUX))
		else $error("request fell without software write");
	cover property (flagWrite ##2 $fell(irqRequest));
endmodule : uscf_serial_port_monitor
bind uscf_serial_port uscf_serial_port_monitor u_monitor (.sysClk(sysClk), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .rxdPin(rxdPin), .txdPin(txdPin), .irqRequest(irqRequest));

// ==== uscf_peer.sv ====
// serial peer on the far side of the two serial pins
`timescale 1ns/10ps
module uscf_peer #(
	parameter int DIV = 8
) (
	input wire logic sysClk,
	input wire logic txdPin,
	input wire logic nineBit,
	output logic rxdPin
);
	logic [9:0] gotQ[$]; // frames: stop, ninth or stop, byte
	time startTime; // moment of the last start edge
	// line rests at its pull-up level
	initial begin
		rxdPin = 1'b1;
	end
	always begin : capture
		logic [9:0] w;
		w = 10'h3FF;
		@(negedge txdPin);
		startTime = $time;
		repeat (DIV / 2) @(posedge sysClk);
		for (int i = 0; i < (nineBit ? 10 : 9); i++) begin
			repeat (DIV) @(posedge sysClk);
			w[i] = txdPin;
		end
		gotQ.push_back(w);
	end
	// ninth bit only in nine-bit frames
	task automatic sendFrame(input logic [7:0] d, input logic nine, input logic extra, input logic stop);
		rxdPin <= 1'b0;
		repeat (DIV) @(posedge sysClk);
		for (int i = 0; i < 8; i++) begin
			rxdPin <= d[i];
			repeat (DIV) @(posedge sysClk);
		end
		if (nine) begin
			rxdPin <= extra;
			repeat (DIV) @(posedge sysClk);
		end
		rxdPin <= stop;
		repeat (DIV) @(posedge sysClk);
		rxdPin <= 1'b1;
	endtask : sendFrame
endmodule : uscf_peer

// ==== uscf_serial_port_tb_top.sv ====
// bench of the serial port: bus, transmit, receive and fifo scenarios
`timescale 1ns/10ps
`include "uscf_defs.svh"
module uscf_serial_port_tb_top;
	logic sysClk, nrst, psel, penable, pwrite, pready, pslverr, rxdPin, txdPin, irqRequest, nineBit;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	int num_errors, checked, cycles;
	// mode, match enable, receive enable, ninth or stop, flag expected
	localparam logic [4:0] CASES [7] = '{5'b00111, 5'b00101, 5'b01100, 5'b10101, 5'b11100, 5'b11111, 5'b00010};
	uscf_serial_port u_dut (.sysClk(sysClk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxdPin(rxdPin), .txdPin(txdPin), .irqRequest(irqRequest));
	uscf_peer #(.DIV(8)) u_peer (.sysClk(sysClk), .txdPin(txdPin), .nineBit(nineBit), .rxdPin(rxdPin));
	initial begin
		sysClk = 1'b0;
		forever #2 sysClk = ~sysClk;
	end
	// hang guard, well above the few thousand cycles needed
	always @(posedge sysClk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			summarize();
		end
	end
	task automatic compare(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
		end
	endtask : compare
	// one transfer; holds everything until ready is sampled, then idles a cycle
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e, output int n);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sysClk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sysClk);
			n++;
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sysClk);
	endtask : apb
	task automatic t_regs();
		logic [31:0] q;
		logic e;
		int n;
		apb(1'b0, `USCF_OFS_CTRL, 32'h0000_0000, q, e, n);
		compare(q, 32'h0000_0040, "control reset");
		apb(1'b0, `USCF_OFS_DIV, 32'h0000_0000, q, e, n);
		compare(q, 32'h0000_087A, "divider reset");
		apb(1'b0, 8'h10, 32'h0000_0000, q, e, n);
		compare({31'h0000_0000, e}, 32'h0000_0001, "unmapped error");
		apb(1'b1, `USCF_OFS_DIV, 32'h0000_0008, q, e, n);
		apb(1'b0, `USCF_OFS_DIV, 32'h0000_0000, q, e, n);
		compare(q, 32'h0000_0008, "divider readback");
	endtask : t_regs
	task automatic t_tx();
		logic [31:0] q;
		logic [9:0] w;
		logic e;
		int n;
		apb(1'b1, `USCF_OFS_AUX, 32'h0000_0001, q, e, n);
		for (int k = 0; k < 4; k++) begin
			nineBit <= k[1];
			apb(1'b1, `USCF_OFS_CTRL, (32'(k[1]) << 7) | (32'(k[0]) << 3), q, e, n);
			apb(1'b1, `USCF_OFS_DATA, 32'h0000_00A5 ^ 32'(k), q, e, n);
			compare({31'h0000_0000, irqRequest}, 32'h0000_0000, "flag cleared");
			@(posedge irqRequest);
			compare(32'(($time - u_peer.startTime) / 4), k[1] ? 32'h0000_0052 : 32'h0000_004A, "flag moment");
			repeat (48) @(posedge sysClk);
			compare({31'h0000_0000, irqRequest}, 32'h0000_0001, "flag holds");
			wait (u_peer.gotQ.size() > 0);
			w = u_peer.gotQ.pop_front();
			compare(32'(w), {22'h00_0000, 1'b1, k[1] ? k[0] : 1'b1, 8'hA5 ^ 8'(k)}, "sent frame");
		end
	endtask : t_tx
	task automatic t_rx();
		logic [31:0] q;
		logic [4:0] c;
		logic [7:0] last;
		logic e;
		int n;
		last = 8'h00;
		for (int i = 0; i < 7; i++) begin
			c = CASES[i];
			apb(1'b1, `USCF_OFS_CTRL, {24'h00_0000, c[4], 1'b0, c[3], c[2], 4'h0}, q, e, n);
			u_peer.sendFrame(8'h30 + 8'(i), c[4], c[1], c[4] | c[1]);
			apb(1'b0, `USCF_OFS_CTRL, 32'h0000_0000, q, e, n);
			compare(32'(q[0]), 32'(c[0]), "receive flag");
			if (c[0]) begin
				compare(32'(q[2]), 32'(c[1]), "ninth receive");
				last = 8'h30 + 8'(i);
			end
			apb(1'b0, `USCF_OFS_DATA, 32'h0000_0000, q, e, n);
			compare(q, 32'(last), "receive latch");
		end
	endtask : t_rx
	task automatic t_fifo();
		logic [31:0] q;
		logic [9:0] w;
		logic e;
		int n;
		nineBit <= 1'b0;
		apb(1'b1, `USCF_OFS_CTRL, 32'h0000_0010, q, e, n);
		for (int i = 0; i < 10; i++) begin
			if (i == 9) begin
				apb(1'b0, `USCF_OFS_AUX, 32'h0000_0000, q, e, n);
				compare(q & 32'h0000_0006, 32'h0000_0006, "full and busy");
			end
			apb(1'b1, `USCF_OFS_DATA, 32'h0000_0050 + 32'(i), q, e, n);
			if (i == 0) begin
				compare(32'(n), 32'h0000_0002, "one wait state");
			end
		end
		compare(32'(n > 20), 32'h0000_0001, "write stalled while full");
		apb(1'b1, `USCF_OFS_CTRL, 32'h0000_0000, q, e, n);
		for (int i = 0; i < 10; i++) begin
			wait (u_peer.gotQ.size() > 0);
			w = u_peer.gotQ.pop_front();
			compare(32'(w), 32'h0000_0350 + 32'(i), "fifo order");
		end
		repeat (20) @(posedge sysClk);
		apb(1'b0, `USCF_OFS_AUX, 32'h0000_0000, q, e, n);
		compare(q & 32'h0000_000E, 32'h0000_0000, "drained");
	endtask : t_fifo
	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize
	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		nineBit = 1'b0;
		repeat (3) @(posedge sysClk);
		nrst <= 1'b1;
		@(posedge sysClk);
		t_regs();
		t_tx();
		t_rx();
		t_fifo();
		summarize();
	end
endmodule : uscf_serial_port_tb_top
